// ---- sfepu_defines.vh ----
/*
 * Constants for the serial flash command engine: opcodes, phase codes,
 * reset values and worst-case cycle times. Assumes a 25 MHz core clock.
 */
`ifndef SFEPU_DEFINES_VH
`define SFEPU_DEFINES_VH

`define SFEPU_CLK_MHZ        25
`define SFEPU_CLK_KHZ        25000

`define SFEPU_OP_WR_UNLOCK   8'h06
`define SFEPU_OP_WRDI        8'h04
`define SFEPU_OP_RDSR        8'h05
`define SFEPU_OP_WRSR        8'h01
`define SFEPU_OP_PP          8'h02
`define SFEPU_OP_SE          8'h20
`define SFEPU_OP_HBE         8'h52
`define SFEPU_OP_FBE         8'hD8
`define SFEPU_OP_CE_A        8'h60
`define SFEPU_OP_CE_B        8'hC7
`define SFEPU_OP_SLEEP       8'hB9
`define SFEPU_OP_WAKE        8'hAB
`define SFEPU_OP_MAKER       8'h90
`define SFEPU_OP_SECRD       8'h2B
`define SFEPU_OP_SECWR       8'h2F
`define SFEPU_OP_QREAD       8'hEB

`define SFEPU_ERASED_BYTE    8'hFF
`define SFEPU_STATUS_RST     8'h00
`define SFEPU_ENH_EXIT       8'hFF
`define SFEPU_ADDR_BYTES     2'd3
`define SFEPU_MAKER_FIRST    8'h00

`define SFEPU_BIT_BUSY       0
`define SFEPU_BIT_WEL        1

`define SFEPU_PH_OP          3'd0
`define SFEPU_PH_ADDR        3'd1
`define SFEPU_PH_DIN         3'd2
`define SFEPU_PH_OUT         3'd3
`define SFEPU_PH_IGNORE      3'd4

`define SFEPU_T_WRITE_US     300
`define SFEPU_T_WRSR_MS      40
`define SFEPU_T_SE_MS        150
`define SFEPU_T_HBE_MS       300
`define SFEPU_T_FBE_MS       500
`define SFEPU_T_CE_S         25
`define SFEPU_T_BYTE_US      30
`define SFEPU_T_PAGE_LO_US   800
`define SFEPU_T_PAGE_HI_US   2000

`endif

// ---- sfepu_busy_timer.v ----
/*
 * Busy-cycle down counter for internal program and erase cycles.
 * Assumes start is a one-cycle pulse on core_clk, ignored while busy.
 */
`timescale 1ns/1ps
module sfepu_busy_timer (
  core_clk,
  reset_n,
  start,
  load_cycles,
  busy
);
  input  wire        core_clk;
  input  wire        reset_n;
  input  wire        start;
  input  wire [31:0] load_cycles;
  output wire        busy;

  reg [31:0] count_q;

  assign busy = (count_q != 32'h0);

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= 32'h0;
    end else if (start && !busy) begin
      count_q <= load_cycles;
    end else if (busy) begin
      count_q <= count_q - 32'h1;
    end
  end
endmodule

// ---- sfepu_core.v ----
/*
 * Device-side command engine of a serial multi-I/O NOR flash: erase,
 * program and register-write busy timing, deep power-down, identity and
 * security register reads, quad read enhance mode.
 * Assumes the pins come from an external host in SPI mode 0 and that
 * core_clk runs much faster than the serial clock.
 */
`timescale 1ns/1ps
`include "sfepu_defines.vh"

// Functional notes
// - opcode 52 erases a 32KB block, also in quad command mode
// - opcode D8 erases a 64KB block in single and quad mode
// - opcodes 60 and C7 both erase the whole array, either mode
// - opcode B9 enters deep power-down, also in quad mode
// - opcode AB wakes and returns signature, single-line mode only
// - opcode 90 returns maker and device code, refused in quad mode
// - address 00h sends maker code first, 01h device code first
// - opcode 2B reads security register, also in quad mode
// - opcode 2F writes security register in single and quad mode
// - a dedicated sequence leaves quad read enhance mode in both modes
// - no write-type instruction runs before 300 us after power-up
// - erased array bytes read as FFh
// - status register holds 00h after delivery
// - status register write finishes within 40 ms
// - 4KB sector erase finishes within 150 ms
// - 32KB block erase finishes within 300 ms
// - 64KB block erase finishes within 500 ms
// - whole-array erase finishes within 25 s
// - page program max 0.8 ms at 10K cycles, 2 ms at 100K
// - each programmed byte takes at most 30 us
// - opcode 06 sets write enable, needed before erase or write
// - enhance mode kept only if every nibble bit pair differs
module sfepu_core #(
  parameter [31:0] WRITE_GATE_CYC = `SFEPU_T_WRITE_US * `SFEPU_CLK_MHZ,
  parameter [31:0] WRSR_CYC       = `SFEPU_T_WRSR_MS * `SFEPU_CLK_KHZ,
  parameter [31:0] SE_CYC         = `SFEPU_T_SE_MS * `SFEPU_CLK_KHZ,
  parameter [31:0] HBE_CYC        = `SFEPU_T_HBE_MS * `SFEPU_CLK_KHZ,
  parameter [31:0] FBE_CYC        = `SFEPU_T_FBE_MS * `SFEPU_CLK_KHZ,
  parameter [31:0] CE_CYC         = `SFEPU_T_CE_S * 1000 * `SFEPU_CLK_KHZ,
  parameter [31:0] BYTE_CYC       = `SFEPU_T_BYTE_US * `SFEPU_CLK_MHZ,
  parameter [31:0] PAGE_LO_CYC    = `SFEPU_T_PAGE_LO_US * `SFEPU_CLK_MHZ,
  parameter [31:0] PAGE_HI_CYC    = `SFEPU_T_PAGE_HI_US * `SFEPU_CLK_MHZ,
  parameter [7:0]  MAKER_CODE     = 8'h5A,  // arbitrary value
  parameter [7:0]  DEVICE_CODE    = 8'h3C   // arbitrary value
) (
  core_clk,
  reset_n,
  spi_cs_n,
  spi_sck,
  io_in,
  io_out,
  io_oe,
  quad_command_mode,
  high_wear,
  busy,
  asleep,
  enhance_active,
  write_ready
);
  input  wire       core_clk;
  input  wire       reset_n;
  input  wire       spi_cs_n;
  input  wire       spi_sck;
  input  wire [3:0] io_in;
  output wire [3:0] io_out;
  output wire [3:0] io_oe;
  input  wire       quad_command_mode;
  input  wire       high_wear;
  output wire       busy;
  output wire       asleep;
  output wire       enhance_active;
  output wire       write_ready;

  reg  [1:0]  cs_sync_q;
  reg         cs_prev_q;
  reg  [1:0]  sck_sync_q;
  reg         sck_prev_q;
  reg  [3:0]  io_s1_q;
  reg  [3:0]  io_s2_q;
  reg  [31:0] pu_cnt_q;
  reg         pu_done_q;
  reg         quad_q;
  reg  [2:0]  ph_q;
  reg  [7:0]  op_q;
  reg  [7:0]  sh_q;
  reg  [3:0]  bits_q;
  reg  [1:0]  addr_cnt_q;
  reg  [7:0]  addr_lo_q;
  reg         ind_next_q;
  reg  [8:0]  prog_bytes_q;
  reg  [7:0]  din_q;
  reg         din_seen_q;
  reg  [7:0]  out_q;
  reg         out_fresh_q;
  reg         id_sel_q;
  reg         wel_q;
  reg         sleep_q;
  reg         enh_q;
  reg  [7:0]  stat_q;
  reg  [7:0]  sec_q;
  reg         start_q;
  reg  [31:0] load_q;

  wire        cs_n      = cs_sync_q[1];
  wire        frame_beg = cs_prev_q & ~cs_n;
  wire        frame_end = ~cs_prev_q & cs_n;
  wire        sck_rise  = sck_sync_q[1] & ~sck_prev_q;
  wire        sck_fall  = ~sck_sync_q[1] & sck_prev_q;
  wire [7:0]  next_sh   = quad_q ? {sh_q[3:0], io_s2_q} :
                                   {sh_q[6:0], io_s2_q[0]};
  wire [3:0]  next_bits = bits_q + (quad_q ? 4'd4 : 4'd1);
  wire        byte_done = ~cs_n & sck_rise & (next_bits == 4'd8);
  wire [7:0]  status_rd = {stat_q[7:2], wel_q, busy};
  wire        addr_ok   = (addr_cnt_q == `SFEPU_ADDR_BYTES);
  wire        wr_ok     = wel_q & ~busy & pu_done_q & ~sleep_q;
  wire [31:0] page_max  = high_wear ? PAGE_HI_CYC : PAGE_LO_CYC;
  wire [31:0] prog_cyc  = {23'h0, prog_bytes_q} * BYTE_CYC;

  // opcodes that are followed by three address bytes
  function takes_addr;
    input [7:0] op;
    begin
      takes_addr = (op == `SFEPU_OP_HBE) || (op == `SFEPU_OP_FBE) ||
                   (op == `SFEPU_OP_SE) || (op == `SFEPU_OP_PP) ||
                   (op == `SFEPU_OP_MAKER) || (op == `SFEPU_OP_WAKE) ||
                   (op == `SFEPU_OP_QREAD);
    end
  endfunction

  // performance indicator keeps the mode only when all bit pairs toggle
  function ind_toggles;
    input [7:0] b;
    begin
      ind_toggles = &(b[7:4] ^ b[3:0]);
    end
  endfunction

  sfepu_busy_timer u_timer (
    .core_clk    (core_clk),
    .reset_n     (reset_n),
    .start       (start_q),
    .load_cycles (load_q),
    .busy        (busy)
  );

  // the driven lanes in either mode come from the output shift flop
  assign io_out = quad_q ? out_q[7:4] : {2'b00, out_q[7], 1'b0};
  assign io_oe  = (~cs_n && ph_q == `SFEPU_PH_OUT) ?
                  (quad_q ? 4'hF : 4'h2) : 4'h0;
  assign asleep         = sleep_q;
  assign enhance_active = enh_q;
  assign write_ready    = pu_done_q;

  // pins are asynchronous to core_clk
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_sync_q  <= 2'b11;
      cs_prev_q  <= 1'b1;
      sck_sync_q <= 2'b00;
      sck_prev_q <= 1'b0;
      io_s1_q    <= 4'h0;
      io_s2_q    <= 4'h0;
    end else begin
      cs_sync_q  <= {cs_sync_q[0], spi_cs_n};
      cs_prev_q  <= cs_sync_q[1];
      sck_sync_q <= {sck_sync_q[0], spi_sck};
      sck_prev_q <= sck_sync_q[1];
      io_s1_q    <= io_in;
      io_s2_q    <= io_s1_q;
    end
  end

  // write gate after power-up; reset_n stands for the supply ramp
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pu_cnt_q  <= 32'h0;
      pu_done_q <= 1'b0;
    end else if (!pu_done_q) begin
      pu_cnt_q  <= pu_cnt_q + 32'h1;
      pu_done_q <= (pu_cnt_q + 32'h1 >= WRITE_GATE_CYC);
    end
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      quad_q       <= 1'b0;
      ph_q         <= `SFEPU_PH_IGNORE;
      op_q         <= 8'h00;
      sh_q         <= 8'h00;
      bits_q       <= 4'h0;
      addr_cnt_q   <= 2'd0;
      addr_lo_q    <= 8'h00;
      ind_next_q   <= 1'b0;
      prog_bytes_q <= 9'h0;
      din_q        <= 8'h00;
      din_seen_q   <= 1'b0;
      out_q        <= 8'h00;
      out_fresh_q  <= 1'b0;
      id_sel_q     <= 1'b0;
      wel_q        <= 1'b0;
      sleep_q      <= 1'b0;
      enh_q        <= 1'b0;
      stat_q       <= `SFEPU_STATUS_RST;
      sec_q        <= 8'h00;
      start_q      <= 1'b0;
      load_q       <= 32'h0;
    end else begin
      start_q <= 1'b0;
      if (frame_beg) begin
        quad_q       <= quad_command_mode;
        bits_q       <= 4'h0;
        addr_cnt_q   <= 2'd0;
        ind_next_q   <= 1'b0;
        prog_bytes_q <= 9'h0;
        din_seen_q   <= 1'b0;
        // enhance mode: frame starts straight with the address
        if (enh_q && !sleep_q) begin
          op_q <= `SFEPU_OP_QREAD;
          ph_q <= `SFEPU_PH_ADDR;
        end else begin
          ph_q <= `SFEPU_PH_OP;
        end
      end else if (sck_fall && !cs_n && ph_q == `SFEPU_PH_OUT) begin
        if (out_fresh_q) begin
          out_fresh_q <= 1'b0;
        end else begin
          out_q <= quad_q ? {out_q[3:0], 4'h0} : {out_q[6:0], 1'b0};
        end
      end else if (sck_rise && !cs_n) begin
        sh_q   <= next_sh;
        bits_q <= byte_done ? 4'h0 : next_bits;
        if (byte_done) begin
          case (ph_q)
            `SFEPU_PH_OP: begin
              op_q <= next_sh;
              if (sleep_q && next_sh != `SFEPU_OP_WAKE) begin
                ph_q <= `SFEPU_PH_IGNORE;
              end else if (quad_q && (next_sh == `SFEPU_OP_WAKE ||
                           next_sh == `SFEPU_OP_MAKER)) begin
                ph_q <= `SFEPU_PH_IGNORE;
              end else if (takes_addr(next_sh)) begin
                ph_q <= `SFEPU_PH_ADDR;
              end else if (next_sh == `SFEPU_OP_RDSR) begin
                ph_q        <= `SFEPU_PH_OUT;
                out_q       <= status_rd;
                out_fresh_q <= 1'b1;
              end else if (next_sh == `SFEPU_OP_SECRD) begin
                ph_q        <= `SFEPU_PH_OUT;
                out_q       <= sec_q;
                out_fresh_q <= 1'b1;
              end else begin
                ph_q <= `SFEPU_PH_DIN;
              end
            end
            `SFEPU_PH_ADDR: begin
              addr_cnt_q <= addr_cnt_q + 2'd1;
              addr_lo_q  <= next_sh;
              if (op_q == `SFEPU_OP_QREAD && enh_q && addr_cnt_q == 2'd0 &&
                  next_sh == `SFEPU_ENH_EXIT) begin
                enh_q <= 1'b0;
                ph_q  <= `SFEPU_PH_IGNORE;
              end else if (addr_cnt_q == 2'd2) begin
                out_fresh_q <= 1'b1;
                if (op_q == `SFEPU_OP_MAKER) begin
                  ph_q     <= `SFEPU_PH_OUT;
                  id_sel_q <= (next_sh != `SFEPU_MAKER_FIRST);
                  out_q    <= (next_sh == `SFEPU_MAKER_FIRST) ?
                              MAKER_CODE : DEVICE_CODE;
                end else if (op_q == `SFEPU_OP_WAKE) begin
                  ph_q    <= `SFEPU_PH_OUT;
                  sleep_q <= 1'b0;
                  out_q   <= DEVICE_CODE;
                end else begin
                  ph_q       <= `SFEPU_PH_DIN;
                  ind_next_q <= (op_q == `SFEPU_OP_QREAD);
                end
              end
            end
            `SFEPU_PH_DIN: begin
              din_q      <= next_sh;
              din_seen_q <= 1'b1;
              if (op_q == `SFEPU_OP_PP && prog_bytes_q != 9'h100) begin
                prog_bytes_q <= prog_bytes_q + 9'h1;
              end
              if (ind_next_q) begin
                ind_next_q  <= 1'b0;
                enh_q       <= ind_toggles(next_sh);
                ph_q        <= `SFEPU_PH_OUT;
                out_q       <= `SFEPU_ERASED_BYTE;
                out_fresh_q <= 1'b1;
              end
            end
            `SFEPU_PH_OUT: begin
              out_fresh_q <= 1'b1;
              if (op_q == `SFEPU_OP_MAKER) begin
                id_sel_q <= ~id_sel_q;
                out_q    <= id_sel_q ? MAKER_CODE : DEVICE_CODE;
              end else if (op_q == `SFEPU_OP_RDSR) begin
                out_q <= status_rd;
              end else if (op_q == `SFEPU_OP_SECRD) begin
                out_q <= sec_q;
              end else if (op_q == `SFEPU_OP_WAKE) begin
                out_q <= DEVICE_CODE;
              end else begin
                out_q <= `SFEPU_ERASED_BYTE;
              end
            end
            default: begin
              ph_q <= `SFEPU_PH_IGNORE;
            end
          endcase
        end
      end else if (frame_end) begin
        // commands act on deselect, and only on a whole last byte
        if (bits_q == 4'h0 && (ph_q == `SFEPU_PH_DIN ||
            ph_q == `SFEPU_PH_ADDR)) begin
          case (op_q)
            `SFEPU_OP_WR_UNLOCK: begin
              wel_q <= 1'b1;
            end
            `SFEPU_OP_WRDI: begin
              wel_q <= 1'b0;
            end
            `SFEPU_OP_SLEEP: begin
              if (!busy) begin
                sleep_q <= 1'b1;
              end
            end
            `SFEPU_OP_SE, `SFEPU_OP_HBE, `SFEPU_OP_FBE: begin
              if (wr_ok && addr_ok) begin
                wel_q   <= 1'b0;
                start_q <= 1'b1;
                if (op_q == `SFEPU_OP_SE) begin
                  load_q <= SE_CYC;
                end else if (op_q == `SFEPU_OP_HBE) begin
                  load_q <= HBE_CYC;
                end else begin
                  load_q <= FBE_CYC;
                end
              end
            end
            `SFEPU_OP_CE_A, `SFEPU_OP_CE_B: begin
              if (wr_ok) begin
                wel_q   <= 1'b0;
                start_q <= 1'b1;
                load_q  <= CE_CYC;
              end
            end
            `SFEPU_OP_PP: begin
              if (wr_ok && prog_bytes_q != 9'h0) begin
                wel_q   <= 1'b0;
                start_q <= 1'b1;
                // per-byte time, capped by the wear-dependent page max
                load_q  <= (prog_cyc > page_max) ?
                           page_max : prog_cyc;
              end
            end
            `SFEPU_OP_WRSR: begin
              if (wr_ok && din_seen_q) begin
                wel_q   <= 1'b0;
                stat_q  <= {din_q[7:2], 2'b00};
                start_q <= 1'b1;
                load_q  <= WRSR_CYC;
              end
            end
            `SFEPU_OP_SECWR: begin
              // one-time bits: they can be set but never cleared
              if (wr_ok && din_seen_q) begin
                wel_q <= 1'b0;
                sec_q <= sec_q | din_q;
              end
            end
            default: begin
              wel_q <= wel_q;
            end
          endcase
        end
        ph_q <= `SFEPU_PH_IGNORE;
      end
    end
  end
endmodule

// ---- sfepu_core_sva.sv ----
/* checker for the flash command engine ports.
   assumes one core clock domain and async active-low reset. */
`timescale 1ns/1ps
module sfepu_core_sva #(
  parameter [31:0] WRITE_GATE_CYC = 32'd400,
  parameter [31:0] CE_CYC         = 32'd2000
) (
  input wire       core_clk,
  input wire       reset_n,
  input wire       spi_cs_n,
  input wire [3:0] io_oe,
  input wire       busy,
  input wire       asleep,
  input wire       write_ready
);
  reg [31:0] up_q;
  reg [31:0] run_q;
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      up_q  <= 32'h0;
      run_q <= 32'h0;
    end else begin
      up_q  <= up_q + 32'h1;
      run_q <= busy ? run_q + 32'h1 : 32'h0;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_gate_early: assert property (
    write_ready |-> up_q >= WRITE_GATE_CYC - 1)
    else $error("write gate opened early");
  a_ready_holds: assert property (write_ready |=> write_ready)
    else $error("write gate closed again");
  // the host may select again before busy shows, so look back at the pin
  a_busy_start: assert property (
    $rose(busy) |-> $past(spi_cs_n, 2) && write_ready && !asleep)
    else $error("busy started in a bad state");
  a_sleep_idle: assert property ($rose(asleep) |-> !busy)
    else $error("sleep entered while busy");
  a_sleep_silent: assert property (asleep |-> io_oe == 4'h0)
    else $error("output driven while asleep");
  a_deselect_oe: assert property (spi_cs_n [*4] |-> io_oe == 4'h0)
    else $error("output driven while deselected");
  a_lane_width: assert property (
    io_oe == 4'h0 || io_oe == 4'h2 || io_oe == 4'hF)
    else $error("bad output lane enable");
  a_busy_bound: assert property (run_q <= CE_CYC)
    else $error("busy cycle too long");
  a_wake_single: assert property (
    $fell(asleep) |-> io_oe == 4'h2)
    else $error("woken without single-line answer");
endmodule

// ---- sfepu_host.sv ----
/* host model: drives select, serial clock and io lanes, mode 0.
   assumes io_wire is the resolved pin level from all drivers. */
`timescale 1ns/1ps
module sfepu_host (
  input  wire       core_clk,
  input  wire [3:0] io_wire,
  output reg        spi_cs_n,
  output reg        spi_sck,
  output reg  [3:0] host_io
);
  initial begin
    spi_cs_n = 1'b1;
    spi_sck  = 1'b0;
    host_io  = 4'h0;
  end
  task tick(input integer n);
    begin
      repeat (n) @(posedge core_clk);
      #1;
    end
  endtask
  task start;
    begin
      tick(2);
      spi_cs_n = 1'b0;
      tick(5);
    end
  endtask
  // released lanes flip so a stale value is never mistaken for data
  // wait out the deselect action so callers see its result
  task stop;
    begin
      spi_cs_n = 1'b1;
      host_io  = ~host_io;
      tick(4);
    end
  endtask
  // sck half period of 5 clocks keeps the synchroniser margin
  task xb(input [7:0] tx, input q, output [7:0] rx);
    integer i;
    begin
      rx = 8'h00;
      for (i = 0; i < (q ? 2 : 8); i = i + 1) begin
        if (q)
          host_io = (i == 0) ? tx[7:4] : tx[3:0];
        else
          host_io[0] = tx[7-i];
        tick(5);
        rx = q ? {rx[3:0], io_wire} : {rx[6:0], io_wire[1]};
        spi_sck = 1'b1;
        tick(5);
        spi_sck = 1'b0;
      end
    end
  endtask
endmodule

// ---- sfepu_core_test.sv ----
/* self-checking bench for the flash command engine.
   assumes shortened cycle parameters and the host model. */
`timescale 1ns/1ps
`define CHK(a,e) begin cmp_count=cmp_count+1; if ((a)!==(e)) begin \
 bad_count=bad_count+1; $display("[FAIL] %0t got %h exp %h",$time,a,e); end end
module sfepu_core_test;
  localparam GATE = 400, WRSR = 40, SE = 50, HBE = 60, FBE = 80;
  localparam CE = 2000, PLO = 10, PHI = 14;
  reg         core_clk = 1'b0;
  reg         reset_n = 1'b0;
  reg         qmode = 1'b0;
  reg         high_wear = 1'b0;
  reg  [15:0] rxh = 16'h0;
  integer     bad_count = 0;
  integer     cmp_count = 0;
  integer     cyc = 0;
  integer     c;
  integer     i;
  wire        spi_cs_n;
  wire        spi_sck;
  wire [3:0]  host_io;
  wire [3:0]  io_out;
  wire [3:0]  io_oe;
  wire [3:0]  io_in = (io_oe & io_out) | (~io_oe & host_io);
  wire        busy;
  wire        asleep;
  wire        enhance_active;
  wire        write_ready;
  sfepu_core #(.WRITE_GATE_CYC(GATE), .WRSR_CYC(WRSR), .SE_CYC(SE),
    .HBE_CYC(HBE), .FBE_CYC(FBE), .CE_CYC(CE), .BYTE_CYC(2),
    .PAGE_LO_CYC(PLO), .PAGE_HI_CYC(PHI)) u_sfepu_core (
    .core_clk(core_clk), .reset_n(reset_n), .spi_cs_n(spi_cs_n),
    .spi_sck(spi_sck), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
    .quad_command_mode(qmode), .high_wear(high_wear), .busy(busy),
    .asleep(asleep), .enhance_active(enhance_active),
    .write_ready(write_ready));
  sfepu_host u_sfepu_host (.core_clk(core_clk), .io_wire(io_in),
    .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .host_io(host_io));
  always #20 core_clk = ~core_clk;
  task report_and_stop;
    begin
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      bad_count = bad_count + 1;
      report_and_stop;
    end
  end
  task frame(input q, input integer n, input [95:0] b);
    integer k;
    reg [7:0] r;
    begin
      qmode = q;
      u_sfepu_host.start;
      for (k = n - 1; k >= 0; k = k - 1) begin
        u_sfepu_host.xb(b[8*k +: 8], q, r);
        rxh = {rxh[7:0], r};
      end
      u_sfepu_host.stop;
    end
  endtask
  task write_unlock(input q);
    frame(q, 1, 96'h06);
  endtask
  task busy_len(output integer n);
    integer w;
    begin
      n = 0;
      for (w = 0; w < 20 && busy !== 1'b1; w = w + 1)
        u_sfepu_host.tick(1);
      while (busy === 1'b1 && n < 5000) begin
        u_sfepu_host.tick(1);
        n = n + 1;
      end
    end
  endtask
  task t_powerup;
    begin
      `CHK(write_ready, 1'b0)
      write_unlock(0);
      frame(0, 2, 96'h01FC);
      busy_len(c);
      `CHK(c, 0)
      for (i = 0; i < 500 && write_ready !== 1'b1; i = i + 1)
        u_sfepu_host.tick(1);
      `CHK(write_ready, 1'b1)
      // the refused write left the latch set; drop it before reading
      frame(0, 1, 96'h04);
      frame(0, 2, 96'h0500);
      `CHK(rxh[7:0], 8'h00)
      frame(0, 2, 96'h01FC);
      busy_len(c);
      `CHK(c, 0)
      write_unlock(1);
      frame(1, 2, 96'h01FC);
      busy_len(c);
      `CHK(c, WRSR)
      frame(0, 2, 96'h0500);
      `CHK(rxh[7:0], 8'hFC)
    end
  endtask
  task t_erase;
    reg [7:0] op;
    reg       q;
    integer   e;
    begin
      for (i = 0; i < 6; i = i + 1) begin
        case (i)
          0: begin op = 8'h52; q = 1; e = HBE; end
          1: begin op = 8'hD8; q = 0; e = FBE; end
          2: begin op = 8'hD8; q = 1; e = FBE; end
          3: begin op = 8'h60; q = 0; e = CE; end
          4: begin op = 8'hC7; q = 1; e = CE; end
          default: begin op = 8'h20; q = 0; e = SE; end
        endcase
        write_unlock(q);
        if (i == 3 || i == 4)
          frame(q, 1, {88'h0, op});
        else
          frame(q, 4, {64'h0, op, 24'h012000});
        busy_len(c);
        `CHK(c, e)
        frame(0, 2, 96'h0500);
        `CHK(rxh[1:0], 2'b00)
      end
    end
  endtask
  task t_busy_ignore;
    begin
      write_unlock(0);
      frame(0, 1, 96'h60);
      write_unlock(0);
      frame(0, 4, 96'h20000000);
      `CHK(busy, 1'b1)
      for (i = 0; i < 3000 && busy === 1'b1; i = i + 1)
        u_sfepu_host.tick(1);
      u_sfepu_host.tick(30);
      `CHK(busy, 1'b0)
      // a dropped erase leaves the enable latch untouched
      frame(0, 2, 96'h0500);
      `CHK(rxh[1:0], 2'b10)
    end
  endtask
  task t_page;
    begin
      write_unlock(0);
      frame(0, 8, 96'h02000100_11223344);
      busy_len(c);
      `CHK(c, 8)
      for (i = 0; i < 2; i = i + 1) begin
        high_wear = i[0];
        write_unlock(0);
        frame(0, 12, 96'h02000200_01020304_05060708);
        busy_len(c);
        `CHK(c, i ? PHI : PLO)
      end
      high_wear = 1'b0;
    end
  endtask
  task t_sleep;
    begin
      frame(1, 1, 96'hB9);
      `CHK(asleep, 1'b1)
      write_unlock(0);
      frame(0, 4, 96'hD8030000);
      busy_len(c);
      `CHK(c, 0)
      frame(1, 5, 96'hAB00000000);
      `CHK(asleep, 1'b1)
      frame(0, 5, 96'hAB00000000);
      `CHK(rxh[7:0], 8'h3C)
      `CHK(asleep, 1'b0)
    end
  endtask
  task t_ident_sec;
    begin
      frame(0, 6, 96'h90000000_0000);
      `CHK(rxh, 16'h5A3C)
      frame(0, 6, 96'h90000001_0000);
      `CHK(rxh, 16'h3C5A)
      write_unlock(1);
      frame(1, 2, 96'h2F81);
      frame(0, 2, 96'h2B00);
      `CHK(rxh[7:0], 8'h81)
      write_unlock(0);
      frame(0, 2, 96'h2F02);
      frame(1, 2, 96'h2B00);
      `CHK(rxh[7:0], 8'h83)
    end
  endtask
  task t_enhance;
    begin
      frame(1, 6, 96'hEB000000A5_00);
      `CHK(enhance_active, 1'b1)
      `CHK(rxh[7:0], 8'hFF)
      frame(1, 4, 96'hFFFFFFFF);
      `CHK(enhance_active, 1'b0)
      // enter again, then leave by a non-toggling indicator
      frame(1, 5, 96'hEB000000A5);
      frame(1, 4, 96'h000000AA);
      `CHK(enhance_active, 1'b0)
      frame(1, 5, 96'hEB000000AA);
      `CHK(enhance_active, 1'b0)
    end
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    // supply-to-select wait, scaled down like the write gate
    u_sfepu_host.tick(50);
    t_powerup;
    t_erase;
    t_busy_ignore;
    t_page;
    t_sleep;
    t_ident_sec;
    t_enhance;
    report_and_stop;
  end
endmodule
bind sfepu_core sfepu_core_sva #(.WRITE_GATE_CYC(WRITE_GATE_CYC),
  .CE_CYC(CE_CYC)) u_sfepu_core_sva (.core_clk(core_clk),
  .reset_n(reset_n), .spi_cs_n(spi_cs_n),
  .io_oe(io_oe), .busy(busy),
  .asleep(asleep), .write_ready(write_ready));
